// ---- shared/sync_start_pkg.sv ----
// Package with register map, field positions and timing for sync start
`default_nettype none
package sync_start_pkg;
    // Register byte offsets (AHB-Lite word addresses)
    localparam logic [7:0] OFS_PRE_OPERATION_MODE = 8'h00;
    localparam logic [7:0] OFS_ENVIRONMENT_CONFIG_1 = 8'h04;
    localparam logic [7:0] OFS_AXIS_STATUS = 8'h08;
    localparam logic [7:0] OFS_EVENT_IRQ_ENABLE = 8'h0c;
    localparam logic [7:0] OFS_EVENT_IRQ_CAUSE = 8'h10;
    localparam logic [7:0] OFS_OPERATION_MODE = 8'h14;
    localparam logic [7:0] OFS_COMMAND = 8'h18;
    // Field positions
    localparam int SYNC_MODE_LO = 18;
    localparam logic [1:0] SYNC_MODE_CSTART = 2'h1;
    localparam int EDGE_SEL_BIT = 18;
    localparam int ALT_POL_BIT = 24;
    localparam int ALT_EN_BIT = 30;
    localparam int ST_LINE_BIT = 5;
    localparam int ST_ALT_BIT = 8;
    localparam int IRQ_EN_BIT = 12;
    localparam int IRQ_CAUSE_BIT = 13;
    // Operation condition codes
    localparam logic [3:0] COND_IDLE = 4'h0;
    localparam logic [3:0] COND_WAIT_START = 4'h2;
    localparam logic [3:0] COND_RUN = 4'h1;
    // Command codes
    localparam logic [7:0] CMD_START = 8'h01;
    localparam logic [7:0] CMD_SIM_START = 8'h06;
    localparam logic [7:0] CMD_OWN_START = 8'h2a;
    localparam logic [7:0] CMD_IMM_STOP = 8'h49;
    // One-shot length in reference clock cycles
    localparam int ONESHOT_CYCLES = 8;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    // AHB codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic HRESP_OKAY = 1'b0;
    // Axis states
    typedef enum logic [1:0] {AX_IDLE, AX_WAIT, AX_RUN} axis_state_e;
endpackage : sync_start_pkg
`default_nettype wire

// ---- design/axis_external_sync_start.sv ----
// Sync start logic for one axis with AHB-Lite register slave
// Behaviour
// - Mode 01 waits for start line low
// - Start line always active low
// - Start command enters wait state
// - Condition code 0010 while waiting
// - Status bit 5 mirrors active line
// - Config bit 18 selects level or edge
// - Level mode starts at once if low
// - Command 06h drives line low 8 cycles
// - Own one-shot sensed as start input
// - Command 2Ah starts own axis only
// - All waiting axes start on common line
// - Non-sync start runs axis independently
// - Command 49h leaves wait without start
// - Enable bit 12 gates start-line interrupt
// - Cause bit 13 flags start-line event
// - Alternate input replaces line when enabled
// - Config bit 24 sets alternate polarity
// - Status bit 8 shows active alternate
//
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module axis_external_sync_start
    import sync_start_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic start_line_in,
    output logic start_line_out,
    output logic start_line_oe_n,
    input wire logic alternate_start_input,
    output logic irq,
    output logic feeding
);
    import sync_start_pkg::*;

    // Captured address phase
    logic wr_pend_q;
    logic [7:0] addr_q;
    // Register storage
    logic [31:0] pre_operation_mode_q;
    logic [31:0] environment_config_1_q;
    logic [31:0] event_irq_enable_q;
    logic [31:0] operation_mode_q;
    logic cause_q;
    // Synchronisers, first stage read only by second
    logic line_s1_q, line_s2_q, line_s3_q;
    logic alt_s1_q, alt_s2_q, alt_s3_q;
    // One-shot counter
    logic [3:0] shot_cnt_q;
    axis_state_e state_q;
    logic [31:0] rdata_d;

    // Command decode from write data phase
    logic cmd_wr;
    logic [7:0] cmd;
    assign cmd_wr = wr_pend_q && (addr_q == OFS_COMMAND);
    assign cmd = hwdata[7:0];

    // Derived selections
    logic sync_mode, edge_mode, alt_en, alt_pol;
    assign sync_mode = pre_operation_mode_q[SYNC_MODE_LO +: 2]
                       == SYNC_MODE_CSTART;
    assign edge_mode = environment_config_1_q[EDGE_SEL_BIT];
    assign alt_en = environment_config_1_q[ALT_EN_BIT];
    assign alt_pol = environment_config_1_q[ALT_POL_BIT];

    // Active line: fixed low-true, no inversion option
    logic line_act, line_act_prev;
    assign line_act = ~line_s2_q;
    assign line_act_prev = ~line_s3_q;
    // Alternate input after polarity
    logic alt_act, alt_act_prev;
    assign alt_act = alt_pol ? alt_s2_q : ~alt_s2_q;
    assign alt_act_prev = alt_pol ? alt_s3_q : ~alt_s3_q;

    // Trigger source chosen per axis
    logic src_act, src_prev, trig;
    assign src_act = alt_en ? alt_act : line_act;
    assign src_prev = alt_en ? alt_act_prev : line_act_prev;
    // Edge mode fires on fresh activation only
    assign trig = edge_mode ? (src_act && !src_prev) : src_act;

    // Synchronise line and alternate input
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            line_s1_q <= 1'b1;
            line_s2_q <= 1'b1;
            line_s3_q <= 1'b1;
            // Idle level of the negative-logic default, so no false edge
            alt_s1_q <= 1'b1;
            alt_s2_q <= 1'b1;
            alt_s3_q <= 1'b1;
        end else begin
            // Pad reads wire level, so own drive is seen too
            line_s1_q <= start_line_in;
            line_s2_q <= line_s1_q;
            line_s3_q <= line_s2_q;
            alt_s1_q <= alternate_start_input;
            alt_s2_q <= alt_s1_q;
            alt_s3_q <= alt_s2_q;
        end
    end

    // AHB address phase capture; zero wait states
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_pend_q <= 1'b0;
            addr_q <= 8'h00;
        end else if (hready) begin
            wr_pend_q <= hsel && hwrite && htrans[1];
            addr_q <= haddr;
        end
    end

    // Read data registered at address phase
    always_comb begin
        rdata_d = 32'h0000_0000;
        unique case (haddr)
            OFS_PRE_OPERATION_MODE: rdata_d = pre_operation_mode_q;
            OFS_ENVIRONMENT_CONFIG_1: rdata_d = environment_config_1_q;
            OFS_AXIS_STATUS: begin
                rdata_d[3:0] = (state_q == AX_WAIT) ? COND_WAIT_START
                    : (state_q == AX_RUN) ? COND_RUN : COND_IDLE;
                rdata_d[ST_LINE_BIT] = line_act;
                rdata_d[ST_ALT_BIT] = alt_act;
            end
            OFS_EVENT_IRQ_ENABLE: rdata_d = event_irq_enable_q;
            OFS_EVENT_IRQ_CAUSE: rdata_d[IRQ_CAUSE_BIT] = cause_q;
            OFS_OPERATION_MODE: rdata_d = operation_mode_q;
            // Unmapped addresses read zero
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    // Read data output register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && !hwrite && htrans[1]) begin
            hrdata <= rdata_d;
        end
    end

    // Slave never stalls and always answers OKAY
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end
    end

    // Configuration register writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_operation_mode_q <= REG_RESET;
            environment_config_1_q <= REG_RESET;
            event_irq_enable_q <= REG_RESET;
            operation_mode_q <= REG_RESET;
        end else if (wr_pend_q) begin
            unique case (addr_q)
                OFS_PRE_OPERATION_MODE: pre_operation_mode_q <= hwdata;
                OFS_ENVIRONMENT_CONFIG_1: environment_config_1_q <= hwdata;
                OFS_EVENT_IRQ_ENABLE: event_irq_enable_q <= hwdata;
                OFS_OPERATION_MODE: operation_mode_q <= hwdata;
                // Read-only and command locations store nothing
                default: ;
            endcase
        end
    end

    // One-shot driver for the shared line
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shot_cnt_q <= 4'h0;
        end else if (cmd_wr && cmd == CMD_SIM_START) begin
            shot_cnt_q <= 4'(ONESHOT_CYCLES);
        end else if (shot_cnt_q != 4'h0) begin
            shot_cnt_q <= shot_cnt_q - 4'h1;
        end
    end

    // Pin drive: output fixed low, enable low while driving
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            start_line_out <= 1'b0;
            start_line_oe_n <= 1'b1;
        end else begin
            start_line_out <= 1'b0;
            // Open-drain: only ever pulls low, never drives high
            start_line_oe_n <= !((cmd_wr && cmd == CMD_SIM_START)
                || shot_cnt_q > 4'h1);
        end
    end

    // Axis state machine
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= AX_IDLE;
        end else if (cmd_wr && cmd == CMD_IMM_STOP) begin
            state_q <= AX_IDLE;
        end else begin
            unique case (state_q)
                AX_IDLE: begin
                    if (cmd_wr && cmd == CMD_START) begin
                        if (!sync_mode) begin
                            state_q <= AX_RUN;
                        end else if (!edge_mode && src_act) begin
                            state_q <= AX_RUN;
                        end else begin
                            state_q <= AX_WAIT;
                        end
                    end
                end
                AX_WAIT: begin
                    if (cmd_wr && cmd == CMD_OWN_START) begin
                        state_q <= AX_RUN;
                    end else if (trig) begin
                        state_q <= AX_RUN;
                    end
                end
                // Run holds until stopped; pulse logic lives elsewhere
                AX_RUN: ;
            endcase
        end
    end

    // Feeding flag follows run state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            feeding <= 1'b0;
        end else begin
            feeding <= (state_q == AX_RUN);
        end
    end

    // Start-line event: set wins over read-clear
    logic line_event, cause_rd;
    assign line_event = line_act && !line_act_prev;
    assign cause_rd = hready && hsel && !hwrite && htrans[1]
                      && haddr == OFS_EVENT_IRQ_CAUSE;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cause_q <= 1'b0;
        end else if (line_event && event_irq_enable_q[IRQ_EN_BIT]) begin
            cause_q <= 1'b1;
        end else if (cause_rd) begin
            cause_q <= 1'b0;
        end
    end

    // Interrupt output from the sticky cause
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= cause_q && event_irq_enable_q[IRQ_EN_BIT];
        end
    end

    // Checks: every assertion below watches what this block drives

    // The own one-shot holds the wire low for exactly its length
    AST_SIM_START_SHOT: assert property (
        @(posedge clk) disable iff (rst)
        (cmd_wr && cmd == CMD_SIM_START)
        |=> !start_line_oe_n [*8] ##1 start_line_oe_n
    ) else $error("one-shot length wrong");

    // No drive at all once the one-shot has run out
    AST_PIN_RELEASED: assert property (
        @(posedge clk) disable iff (rst)
        (shot_cnt_q <= 4'h1 && !(cmd_wr && cmd == CMD_SIM_START))
        |=> start_line_oe_n
    ) else $error("wire driven outside a one-shot");

    // The pad only ever sinks, so it cannot fight other drivers
    AST_PIN_SINKS_ONLY: assert property (
        @(posedge clk) disable iff (rst)
        !start_line_out
    ) else $error("start wire driven high");

    // A sync start arms the wait unless a level start applies
    AST_WAIT_COND: assert property (
        @(posedge clk) disable iff (rst)
        (state_q == AX_IDLE && cmd_wr && cmd == CMD_START && sync_mode
         && (edge_mode || !src_act))
        |=> state_q == AX_WAIT
    ) else $error("start did not arm wait");

    // Level mode with the source already active starts at once
    AST_LEVEL_IMMEDIATE: assert property (
        @(posedge clk) disable iff (rst)
        (state_q == AX_IDLE && cmd_wr && cmd == CMD_START && sync_mode
         && !edge_mode && src_act) |=> state_q == AX_RUN
    ) else $error("level start not immediate");

    // Outside sync mode the start command runs the axis alone
    AST_NONSYNC_RUN: assert property (
        @(posedge clk) disable iff (rst)
        (state_q == AX_IDLE && cmd_wr && cmd == CMD_START && !sync_mode)
        |=> state_q == AX_RUN
    ) else $error("plain start failed");

    // Immediate stop drops the wait without a start
    AST_STOP_RELEASE: assert property (
        @(posedge clk) disable iff (rst)
        (state_q == AX_WAIT && cmd_wr && cmd == CMD_IMM_STOP)
        |=> state_q == AX_IDLE
    ) else $error("stop did not release wait");

    // Own-axis start runs this axis and leaves the wire alone
    AST_OWN_START: assert property (
        @(posedge clk) disable iff (rst)
        (state_q == AX_WAIT && cmd_wr && cmd == CMD_OWN_START)
        |=> state_q == AX_RUN && start_line_oe_n
    ) else $error("own start misbehaved");

    // A trigger on the selected source releases a waiting axis
    AST_TRIG_START: assert property (
        @(posedge clk) disable iff (rst)
        (state_q == AX_WAIT && trig && !cmd_wr) |=> state_q == AX_RUN
    ) else $error("waiting axis missed trigger");

    // Edge mode ignores a source that was already active
    AST_EDGE_NO_LEVEL: assert property (
        @(posedge clk) disable iff (rst)
        (state_q == AX_WAIT && edge_mode && src_act && src_prev && !cmd_wr)
        |=> state_q == AX_WAIT
    ) else $error("edge mode fired on level");

    // A status read while waiting returns the waiting code
    AST_STATUS_WAIT: assert property (
        @(posedge clk) disable iff (rst)
        (state_q == AX_WAIT && hready && hsel && !hwrite && htrans[1]
         && haddr == OFS_AXIS_STATUS)
        |=> hrdata[3:0] == COND_WAIT_START
    ) else $error("waiting condition code wrong");

    // Feeding follows the run state one cycle later
    AST_FEED_FOLLOWS: assert property (
        @(posedge clk) disable iff (rst)
        state_q == AX_RUN |=> feeding
    ) else $error("feeding flag missing in run");

    // An enabled line event sets the cause, then the interrupt
    AST_IRQ_CAUSE: assert property (
        @(posedge clk) disable iff (rst)
        (line_event && event_irq_enable_q[IRQ_EN_BIT]) |=> cause_q ##1 irq
    ) else $error("start-line interrupt missing");

    // A cleared enable bit keeps the interrupt low
    AST_NO_IRQ_MASKED: assert property (
        @(posedge clk) disable iff (rst)
        !event_irq_enable_q[IRQ_EN_BIT] |=> !irq
    ) else $error("masked interrupt asserted");

    // Main scenarios the stimulus is expected to reach
    COV_EDGE_START: cover property (@(posedge clk) disable iff (rst)
        state_q == AX_WAIT && edge_mode && trig);
    COV_SIM_START: cover property (@(posedge clk) disable iff (rst)
        state_q == AX_WAIT && !start_line_oe_n ##[1:6] state_q == AX_RUN);
    COV_OWN_START: cover property (@(posedge clk) disable iff (rst)
        state_q == AX_WAIT && cmd_wr && cmd == CMD_OWN_START);
    COV_ALT_START: cover property (@(posedge clk) disable iff (rst)
        state_q == AX_WAIT && alt_en && trig);
    COV_STOP_WAIT: cover property (@(posedge clk) disable iff (rst)
        state_q == AX_WAIT && cmd_wr && cmd == CMD_IMM_STOP);
endmodule : axis_external_sync_start
`default_nettype wire

// ---- verif/ext_start_src.sv ----
// Open-collector external start source sharing the start wire
`timescale 1ns/1ps
`default_nettype none
module ext_start_src (
    input wire logic clk,
    input wire logic rst,
    input wire logic fire,
    input wire logic hold,
    input wire logic [7:0] width,
    output logic pull_n
);
    logic [7:0] cnt_q; // Cycles of the pulse still to run

    // One-shot of width cycles; the bench never asks for fewer than 4
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 8'h00;
        end else if (fire) begin
            cnt_q <= width;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end

    // Only ever sinks the wire, so it can never fight a controller
    assign pull_n = !(hold || cnt_q != 8'h00);
endmodule : ext_start_src
`default_nettype wire

// ---- verif/axis_external_sync_start_bench.sv ----
// Self-checking bench for the axis sync start block
`timescale 1ns/1ps
`default_nettype none
module axis_external_sync_start_bench;
    import sync_start_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2; // Whole 32-bit words only
    logic [31:0] hwdata = 32'h0;
    logic alt = 1'b1; // Alternate input, idle high
    logic fire = 1'b0;
    logic hold = 1'b0; // External source keeps the wire low
    logic [7:0] width = 8'h04;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, oe_n, line_out, irq, feeding, pull_n;
    wire logic line;
    int miscompares = 0;
    int tests_run = 0;
    int seed = 32'h6c23;
    int n, sync_on = 0, edge_on = 0;
    logic [3:0] exp_cond = COND_IDLE; // Model of the axis condition

    // Wire has a pull-up; any party pulling low wins
    assign line = (oe_n | line_out) & pull_n;

    axis_external_sync_start dut (.clk(clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .start_line_in(line),
        .start_line_out(line_out), .start_line_oe_n(oe_n),
        .alternate_start_input(alt), .irq(irq), .feeding(feeding));
    ext_start_src far (.clk(clk), .rst(rst), .fire(fire), .hold(hold),
        .width(width), .pull_n(pull_n));

    // Free running 100 MHz clock
    initial forever #5 clk = ~clk;

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        wrap_up();
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("ERROR %0t got %h expected %h", $time, got, exp);
            miscompares++;
        end
    endtask : chk

    // Address phase held until ready is seen at an edge
    task aph(input logic [7:0] a, input logic w);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
    endtask : aph

    task wr(input logic [7:0] a, input logic [31:0] d);
        aph(a, 1'b1);
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
    endtask : wr

    // Read data taken at the edge that ends the data phase
    task rdr(input logic [7:0] a);
        aph(a, 1'b0);
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : rdr

    // Command write plus the model's view of its effect
    task cmd(input logic [7:0] c);
        wr(OFS_COMMAND, {24'h0, c});
        if (c == CMD_IMM_STOP) begin
            exp_cond = COND_IDLE;
        end else if (c == CMD_OWN_START && exp_cond == COND_WAIT_START) begin
            exp_cond = COND_RUN;
        end else if (c == CMD_START && exp_cond == COND_IDLE) begin
            exp_cond = (sync_on == 0 || (edge_on == 0 && hold))
                ? COND_RUN : COND_WAIT_START;
        end
    endtask : cmd

    // Settle the synchronisers, then compare status with the model
    task st;
        repeat (6) @(posedge clk);
        rdr(OFS_AXIS_STATUS);
        chk(32'(rd[3:0]), 32'(exp_cond));
        chk(32'(feeding), 32'(exp_cond == COND_RUN));
    endtask : st

    // External one-shot; the wire rests high a few cycles first
    task pulse(input logic [7:0] w);
        repeat (3) @(posedge clk);
        width <= w;
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        repeat (w + 4) @(posedge clk);
        if (exp_cond == COND_WAIT_START) exp_cond = COND_RUN;
    endtask : pulse

    task wrap_up;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up

    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        // Reset values, including the unmapped word at 0x1c
        for (n = 0; n < 8; n++) begin
            rdr(8'(n * 4));
            chk(rd, REG_RESET);
            chk(32'(hresp), 32'(HRESP_OKAY));
        end
        n = $random(seed);
        wr(OFS_OPERATION_MODE, n);
        rdr(OFS_OPERATION_MODE);
        chk(rd, n);
        wr(OFS_AXIS_STATUS, 32'hffff_ffff);
        st();
        $display("test regs done");
        // Ordinary start outside sync mode, then stop
        cmd(CMD_START);
        st();
        cmd(CMD_IMM_STOP);
        st();
        $display("test plain done");
        // Sync mode, level trigger, external pulse of 4 to 11 cycles
        sync_on = 1;
        wr(OFS_PRE_OPERATION_MODE, 32'(SYNC_MODE_CSTART) << SYNC_MODE_LO);
        cmd(CMD_START);
        st();
        chk(32'(rd[ST_LINE_BIT]), 32'h0);
        pulse(8'(4 + ($random(seed) & 7)));
        st();
        chk(32'(irq), 32'h0);
        cmd(CMD_IMM_STOP);
        $display("test ext done");
        // Own one-shot: width counted, own waiting axis and interrupt
        wr(OFS_EVENT_IRQ_ENABLE, 32'h1 << IRQ_EN_BIT);
        cmd(CMD_START);
        wr(OFS_COMMAND, {24'h0, CMD_SIM_START});
        n = 0;
        repeat (12) begin
            @(posedge clk);
            n += (oe_n === 1'b0 && line_out === 1'b0);
        end
        chk(32'(n), 32'd8);
        exp_cond = COND_RUN;
        st();
        chk(32'(irq), 32'h1);
        rdr(OFS_EVENT_IRQ_CAUSE);
        chk(32'(rd[IRQ_CAUSE_BIT]), 32'h1);
        rdr(OFS_EVENT_IRQ_CAUSE);
        chk(32'(rd[IRQ_CAUSE_BIT]), 32'h0);
        cmd(CMD_IMM_STOP);
        $display("test sim done");
        // Own-axis start leaves the wire alone; stop drops a wait
        cmd(CMD_START);
        cmd(CMD_OWN_START);
        chk(32'(oe_n), 32'h1);
        st();
        cmd(CMD_IMM_STOP);
        cmd(CMD_START);
        cmd(CMD_IMM_STOP);
        pulse(8'h08);
        st();
        $display("test own done");
        // Wire already low: level starts at once, edge waits for a fall
        hold <= 1'b1;
        st();
        chk(32'(rd[ST_LINE_BIT]), 32'h1);
        cmd(CMD_START);
        st();
        cmd(CMD_IMM_STOP);
        edge_on = 1;
        wr(OFS_ENVIRONMENT_CONFIG_1, 32'h1 << EDGE_SEL_BIT);
        cmd(CMD_START);
        st();
        hold <= 1'b0;
        pulse(8'h04);
        st();
        cmd(CMD_IMM_STOP);
        $display("test trig done");
        // Alternate input under both polarities, random levels
        for (n = 0; n < 4; n++) begin
            wr(OFS_ENVIRONMENT_CONFIG_1,
               (32'(n & 1) << ALT_POL_BIT) | (32'h1 << ALT_EN_BIT));
            alt <= 1'($random(seed));
            st();
            chk(32'(rd[ST_ALT_BIT]), 32'(alt == n[0]));
        end
        edge_on = 0;
        alt <= 1'b0;
        cmd(CMD_START);
        st();
        alt <= 1'b1;
        exp_cond = COND_RUN;
        st();
        $display("test alt done");
        wrap_up();
    end
endmodule : axis_external_sync_start_bench
`default_nettype wire
